// ==== rtl/line_tx_encode_pulse_shaper.sv ====
// Transmit front end of one line channel: pin sampling, line coding,
// pulse shaping from preset or user templates, AXI4-Lite registers.
// Assumes pins are asynchronous to clk and the bus master is on clk.
// Behaviour
// R1 - Framer supplies 2.048 MHz transmit clock in E1, 1.544 MHz in T1/J1.
// R2 - Over 70 clk cycles without transmit clock edges flags clock loss.
// R3 - Data sampled on transmit clock edge chosen by edge select bit.
// R4 - Data polarity bit inverts incoming data when set.
// R5 - Coding mode bit 1 clear: single input; set: both rails used.
// R6 - T1/J1 single rail: B8ZS or plain AMI by coding mode bit 0.
// R7 - E1 single rail: HDB3 or plain AMI by coding mode bit 0.
// R8 - Dual rail bypasses the encoder in every line standard.
// R9 - Dual rail: positive only gives negative pulse, reverse positive, equal space.
// R10 - Software picks template 0000 or 0001 for E1 cables.
// R11 - T1 offers five preset templates chosen by template select; every T1 select gives the same shape.
// R12 - Software picks template 0111 for J1.
// R13 - Template select 11xx shapes pulses from the user waveform RAM.
// R14 - User pulse spans four intervals of sixteen sub-phases each.
// R15 - Samples are seven-bit signed magnitude from +63 to -63.
// R16 - Each channel has a 64 entry RAM addressed by interval and sub-phase.
// R17 - Eight standard templates held in a read-only store; the store holds three shapes only.
// R18 - RAM access: set address and data, direction, then trigger bit.
// R19 - Six-bit scale resets to 100001, each step about three percent.
// R20 - Scaling applies to the user waveform only.
// R21 - Summed amplitude past limit sets overflow status and maskable interrupt.
// R22 - E1 75 ohm template: 0001100 at sample 4, 0110000 at 5 to 12.
// R23 - Global standard bit 0 selects E1, 1 selects T1/J1.
// R24 - A completed read leaves the RAM sample in the data register.
`timescale 1ns/1ps
module line_tx_encode_pulse_shaper (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic tx_line_clock,
	input wire logic tx_data_positive,
	input wire logic tx_data_negative,
	input wire logic [`ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [`ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output logic [6:0] line_output_pair,
	output logic irq
);
	import line_tx_pkg::*;

	state_t s;
	state_t n;
	logic lclk_rise;
	logic lclk_fall;
	logic take;
	logic dp;
	logic dn;
	logic user_mode;
	logic ovf;
	logic pol;
	logic [1:0] sym_in;
	logic [5:0] ram_idx;
	logic [7:0] widx;
	logic [7:0] ridx;
	logic signed [9:0] acc;
	logic signed [9:0] term;
	sym_t [7:0] nq;

	// Signed magnitude sample to two's complement
	function automatic logic signed [9:0] sm_to_int(input logic [6:0] v);
		logic signed [9:0] m;
		m = $signed({4'h0, v[5:0]});
		return v[6] ? -m : m;
	endfunction

	// Amplitude scaling; unity at the reset scale value
	function automatic logic signed [9:0] scale_val(input logic signed [9:0] v,
		input logic [5:0] sc);
		logic signed [15:0] p;
		p = 16'(v) * $signed({10'h000, sc});
		p = p / `UNITY_SCALE;
		return p[9:0];
	endfunction

	// Read-only store of three template shapes; selects 2 to 7 all give the T1 one
	function automatic logic [6:0] rom_sample(input logic [2:0] t, input logic [1:0] ui,
		input logic [3:0] sp);
		logic [6:0] edge_v;
		logic [6:0] flat_v;
		case (t)
			3'h0: begin
				edge_v = `E1_75_EDGE;
				flat_v = `E1_75_FLAT;
			end
			3'h1: begin
				edge_v = `E1_120_EDGE;
				flat_v = `E1_120_FLAT;
			end
			default: begin
				edge_v = `T1_EDGE;
				flat_v = `T1_FLAT;
			end
		endcase
		if (ui != 2'h0)
			return 7'h00;
		else if (sp == `EDGE_SP)
			return edge_v;
		else if (sp >= `FLAT_FIRST_SP && sp <= `FLAT_LAST_SP)
			return flat_v;
		else
			return 7'h00;
	endfunction

	// Address decode shared by read and write
	function automatic logic reg_ok(input logic [`ADDR_W-1:0] a);
		logic [7:0] i;
		i = a[9:2];
		return a[1:0] == 2'h0 && (i == `IDX_CFG0 || i == `IDX_CFG1 || i == `IDX_SCALE ||
			i == `IDX_RAMCTL || i == `IDX_RAMDATA || i == `IDX_MASK ||
			i == `IDX_STATUS || i == `IDX_GLOBAL);
	endfunction

	// Register read mux
	function automatic logic [7:0] reg_read(input state_t st, input logic [7:0] i);
		case (i)
			`IDX_CFG0: return st.cfg0;
			`IDX_CFG1: return st.cfg1;
			`IDX_SCALE: return {2'h0, st.scale};
			`IDX_RAMCTL: return st.ramctl;
			`IDX_RAMDATA: return {1'h0, st.ramdata};
			`IDX_MASK: return st.mask;
			`IDX_STATUS: return st.status;
			`IDX_GLOBAL: return {7'h00, st.std};
			default: return 8'h00;
		endcase
	endfunction

	// Next-state logic for the whole block
	always_comb begin
		n = s;
		acc = 10'sh000;
		term = 10'sh000;
		sym_in = 2'h0;
		pol = 1'b0;
		nq = s.q;
		ovf = 1'b0;
		widx = s.waddr[9:2];
		ridx = araddr[9:2];
		ram_idx = s.ramctl[`F_UI_HI:`F_SP_LO];

		// Pin synchronisers; clock and data see equal latency
		n.sync_clk = {s.sync_clk[0], tx_line_clock};
		n.sync_p = {s.sync_p[0], tx_data_positive};
		n.sync_n = {s.sync_n[0], tx_data_negative};
		n.clk_prev = s.sync_clk[1];
		lclk_rise = s.sync_clk[1] & ~s.clk_prev;
		lclk_fall = ~s.sync_clk[1] & s.clk_prev;
		// R3 edge select
		take = s.cfg0[`F_EDGE] ? lclk_fall : lclk_rise;
		// R4 data inversion
		dp = s.sync_p[1] ^ s.cfg0[`F_POL];
		dn = s.sync_n[1] ^ s.cfg0[`F_POL];

		// R2 clock loss count, saturating so it flags once
		if (lclk_rise | lclk_fall)
			n.loss_cnt = 7'h00;
		else if (s.loss_cnt != `LOSS_SAT)
			n.loss_cnt = s.loss_cnt + 7'h01;

		// Symbol per unit interval; sub-phase restarts on each one
		if (take) begin
			if (s.cfg0[`F_DUAL]) begin
				// R5 R8 R9 rails bypass the encoder
				sym_in = {dn & ~dp, dp & ~dn};
			end else begin
				// R5 single input into the coding queue
				nq = {s.q[6:0], dp ? SYM_MARK : SYM_ZERO};
				n.par = s.par ^ dp;
				if (s.cfg0[`F_CODE_EN]) begin
					// R23 R6 eight zeros become 000VB0VB
					if (s.std && nq == {8{SYM_ZERO}}) begin
						nq = {SYM_ZERO, SYM_ZERO, SYM_ZERO, SYM_VIOL,
							SYM_BIP, SYM_ZERO, SYM_VIOL, SYM_BIP};
					// R23 R7 four zeros become 000V or B00V
					end else if (!s.std && nq[3:0] == {4{SYM_ZERO}}) begin
						nq[3] = s.par ? SYM_ZERO : SYM_BIP;
						nq[0] = SYM_VIOL;
						n.par = 1'b0;
					end
				end
				n.q = nq;
				// Alternate marks; a violation repeats the last polarity
				case (s.q[7])
					SYM_MARK, SYM_BIP: begin
						pol = ~s.last_pol;
						n.last_pol = pol;
						sym_in = pol ? 2'b10 : 2'b01;
					end
					SYM_VIOL: sym_in = s.last_pol ? 2'b10 : 2'b01;
					default: sym_in = 2'b00;
				endcase
			end
			n.hist = {s.hist[2:0], sym_in};
			n.sp = 4'h0;
		end else if (s.sp != `SP_LAST) begin
			// Sub-phase holds at the last one if the interval runs long
			n.sp = s.sp + 4'h1;
		end

		// R13 user RAM when template select is 11xx
		user_mode = s.cfg1[3:2] == `USER_TSEL;
		// R14 R15 sum four overlapping intervals
		for (int k = 0; k < 4; k++) begin
			if (user_mode) begin
				// R16 RAM by interval and sub-phase; R19 R20 scale user only
				term = scale_val(sm_to_int(s.ram[{2'(k), s.sp}]), s.scale);
			end else begin
				// R11 R17 R22 preset template store
				term = sm_to_int(rom_sample(s.cfg1[2:0], 2'(k), s.sp));
			end
			if (s.hist[k][1])
				acc = acc + term;
			else if (s.hist[k][0])
				acc = acc - term;
		end
		// R21 overflow detect and clamp
		ovf = acc > `AMP_MAX || acc < -`AMP_MAX;
		if (acc > `AMP_MAX)
			n.line_out = {1'b0, 6'h3f};
		else if (acc < -`AMP_MAX)
			n.line_out = {1'b1, 6'h3f};
		else if (acc < 10'sh000)
			n.line_out = {1'b1, 6'(-acc)};
		else
			n.line_out = {1'b0, acc[5:0]};

		// Write address and data taken in either order
		if (awvalid & s.awready) begin
			n.aw_held = 1'b1;
			n.waddr = awaddr;
			n.awready = 1'b0;
		end
		if (wvalid & s.wready) begin
			n.w_held = 1'b1;
			n.wdata = wdata[7:0];
			n.wstb = wstrb[0];
			n.wready = 1'b0;
		end
		// Write commits once both halves are held
		if (s.aw_held & s.w_held & ~s.bvalid) begin
			n.aw_held = 1'b0;
			n.w_held = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = reg_ok(s.waddr) ? `RESP_OKAY : `RESP_SLVERR;
			if (reg_ok(s.waddr) && s.wstb) begin
				case (widx)
					`IDX_CFG0: n.cfg0 = s.wdata;
					`IDX_CFG1: n.cfg1 = s.wdata;
					`IDX_SCALE: n.scale = s.wdata[5:0];
					`IDX_RAMDATA: n.ramdata = s.wdata[6:0];
					`IDX_MASK: n.mask = s.wdata;
					`IDX_GLOBAL: n.std = s.wdata[`F_STD];
					`IDX_RAMCTL: begin
						// R18 trigger bit starts the access
						if (!s.ram_go) begin
							n.ramctl = s.wdata;
							n.ram_go = s.wdata[`F_DONE];
						end
					end
					default: n.status = s.status;
				endcase
			end
		end
		if (s.bvalid & bready) begin
			n.bvalid = 1'b0;
			n.awready = 1'b1;
			n.wready = 1'b1;
		end

		// R18 RAM access one cycle after the trigger
		if (s.ram_go) begin
			if (s.ramctl[`F_RW])
				// R24 read result lands in the data register
				n.ramdata = s.ram[ram_idx];
			else
				n.ram[ram_idx] = s.ramdata;
			n.ramctl[`F_DONE] = 1'b0;
			n.ram_go = 1'b0;
		end

		// Read channel; status clears when read
		if (arvalid & s.arready) begin
			n.arready = 1'b0;
			n.rvalid = 1'b1;
			n.rdata = reg_ok(araddr) ? reg_read(s, ridx) : 8'h00;
			n.rresp = reg_ok(araddr) ? `RESP_OKAY : `RESP_SLVERR;
			if (reg_ok(araddr) && ridx == `IDX_STATUS)
				n.status = 8'h00;
		end
		if (s.rvalid & rready) begin
			n.rvalid = 1'b0;
			n.arready = 1'b1;
		end

		// R2 R21 events set after the clear so a coincident event wins
		if (s.loss_cnt == `LOSS_LIMIT && !(lclk_rise | lclk_fall))
			n.status[`F_LOSS] = 1'b1;
		if (ovf)
			n.status[`F_OVF] = 1'b1;
		// R2 R21 mask bit set lets the flag through
		n.irq = |(n.status[`F_OVF:`F_LOSS] & n.mask[`F_OVF:`F_LOSS]);
	end

	// State register; clock enable freezes everything
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s <= '0;
			s.scale <= `RST_SCALE;
			s.awready <= 1'b1;
			s.wready <= 1'b1;
			s.arready <= 1'b1;
		end else if (ce) begin
			s <= n;
		end
	end

	// Outputs straight from the state register
	assign awready = s.awready;
	assign wready = s.wready;
	assign bvalid = s.bvalid;
	assign bresp = s.bresp;
	assign arready = s.arready;
	assign rvalid = s.rvalid;
	assign rresp = s.rresp;
	assign rdata = {24'h000000, s.rdata};
	assign line_output_pair = s.line_out;
	assign irq = s.irq;
endmodule

// ==== include/line_tx_defines.svh ====
// Constants for the transmit encoder and pulse shaper: register map,
// field positions, reset values and counts. Included by the package.
`ifndef LINE_TX_DEFINES_SVH
`define LINE_TX_DEFINES_SVH
// Register indices; byte address is four times the index
`define IDX_CFG0 8'h02
`define IDX_CFG1 8'h03
`define IDX_SCALE 8'h04
`define IDX_RAMCTL 8'h05
`define IDX_RAMDATA 8'h06
`define IDX_MASK 8'h12
`define IDX_STATUS 8'h17
`define IDX_GLOBAL 8'h40
`define ADDR_W 10
// Field positions
`define F_CODE_EN 0
`define F_DUAL 1
`define F_POL 2
`define F_EDGE 3
`define F_SP_HI 3
`define F_SP_LO 0
`define F_UI_HI 5
`define F_UI_LO 4
`define F_RW 6
`define F_DONE 7
`define F_LOSS 0
`define F_OVF 1
`define F_STD 0
// Reset values and limits
`define RST_SCALE 6'h21
`define UNITY_SCALE 16'sh0021
`define LOSS_LIMIT 7'h46
`define LOSS_SAT 7'h47
`define AMP_MAX 10'sh03f
`define USER_TSEL 2'h3
`define SP_LAST 4'hf
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
// Preset template shapes: edge sample, then a flat run
`define EDGE_SP 4'h3
`define FLAT_FIRST_SP 4'h4
`define FLAT_LAST_SP 4'hb
`define E1_75_EDGE 7'h0c
`define E1_75_FLAT 7'h30
`define E1_120_EDGE 7'h0f
`define E1_120_FLAT 7'h3c
`define T1_EDGE 7'h10
`define T1_FLAT 7'h30
`endif

// ==== include/line_tx_pkg.sv ====
// Types for the transmit encoder and pulse shaper.
// Assumes line_tx_defines.svh sits on the include path.
`include "line_tx_defines.svh"
package line_tx_pkg;
	// Line symbol codes held in the encoder queue
	typedef enum logic [1:0] {SYM_ZERO, SYM_MARK, SYM_VIOL, SYM_BIP} sym_t;

	// Whole state of the block
	typedef struct packed {
		logic [1:0] sync_clk;
		logic [1:0] sync_p;
		logic [1:0] sync_n;
		logic clk_prev;
		logic [6:0] loss_cnt;
		logic [7:0] cfg0;
		logic [7:0] cfg1;
		logic [5:0] scale;
		logic [7:0] ramctl;
		logic [6:0] ramdata;
		logic [7:0] mask;
		logic [7:0] status;
		logic std;
		logic [63:0][6:0] ram;
		logic ram_go;
		sym_t [7:0] q;
		logic par;
		logic last_pol;
		logic [3:0][1:0] hist;
		logic [3:0] sp;
		logic [6:0] line_out;
		logic irq;
		logic awready;
		logic wready;
		logic aw_held;
		logic w_held;
		logic [`ADDR_W-1:0] waddr;
		logic [7:0] wdata;
		logic wstb;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [7:0] rdata;
		logic [1:0] rresp;
	} state_t;
endpackage

// ==== testbench/line_tx_properties.sv ====
// Bus checks for the line transmit block, bound to its top module.
// Assumes the defines header is on the include path.
`timescale 1ns/1ps
`include "line_tx_defines.svh"
module line_tx_properties (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [`ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [`ADDR_W-1:0] araddr,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	input wire logic rready
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Both halves of a write taken together
	sequence wr_both;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence wr_bad;
		wr_both ##0 awaddr[1:0] != 2'h0;
	endsequence
	// Both halves are held one edge after the handshake; the answer follows on the next
	write_answer_a: assert property (wr_both |-> ##2 bvalid)
		else $error("write not answered");
	write_slverr_a: assert property (wr_bad |-> ##2 bvalid && bresp == 2'h2)
		else $error("unaligned write accepted");
	resp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped");
	aw_refuse_a: assert property (awvalid && awready |=> !awready)
		else $error("second write address taken");
	read_answer_a: assert property (arvalid && arready |=> rvalid && rdata[31:8] == 24'h0)
		else $error("read not answered");
	read_slverr_a: assert property (arvalid && arready && araddr[1:0] != 2'h0
		|=> rresp == 2'h2 && rdata == 32'h0) else $error("unaligned read accepted");
	read_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped");
	read_refuse_a: assert property (rvalid |-> !arready)
		else $error("read taken while busy");
endmodule
bind line_tx_encode_pulse_shaper line_tx_properties chk_i (.clk(clk), .rst_n(rst_n),
	.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
	.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
	.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
	.rvalid(rvalid), .rready(rready));

// ==== testbench/framer_model.sv ====
// Behavioural framer driving line clock and data rails.
// Assumes go pulses with pattern and edge inputs already stable.
`timescale 1ns/1ps
module framer_model (
	input wire logic go,
	input wire logic fall,
	input wire logic [15:0] pos,
	input wire logic [15:0] neg,
	output logic lclk,
	output logic dp,
	output logic dn,
	output logic busy,
	output logic late
);
	initial begin
		{lclk, dp, dn, busy, late} = 5'h0;
	end
	// Sixteen bits, clock still between frames; offset avoids clk edges
	always @(posedge go) begin
		busy = 1'b1;
		#7;
		for (int k = 15; k >= 0; k--) begin
			late = k < 6;
			if (fall)
				lclk = 1'b1;
			dp = pos[k];
			dn = neg[k];
			#80 lclk = !fall;
			#80 lclk = 1'b0;
		end
		// Released rails show the inverse
		dp = !dp;
		dn = !dn;
		{busy, late} = 2'h0;
	end
endmodule

// ==== testbench/line_tx_encode_pulse_shaper_test.sv ====
// Self-checking bench for the line transmit encoder and pulse shaper.
// Assumes design, checker and framer model are compiled first.
`timescale 1ns/1ps
module line_tx_encode_pulse_shaper_test;
	import line_tx_pkg::*;
	logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, go, fall;
	logic ce;
	logic awready, wready, bvalid, arready, rvalid, irq, lclk, dp, dn, busy, late;
	logic [9:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp, seen, rs;
	logic [6:0] lo;
	logic [7:0] rv;
	logic [5:0] mx;
	logic [15:0] pos, neg;
	int fail_count, checked;
	line_tx_encode_pulse_shaper dut (.clk(clk), .rst_n(rst_n), .ce(ce),
		.tx_line_clock(lclk), .tx_data_positive(dp), .tx_data_negative(dn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.line_output_pair(lo), .irq(irq));
	framer_model fm (.go(go), .fall(fall), .pos(pos), .neg(neg), .lclk(lclk),
		.dp(dp), .dn(dn), .busy(busy), .late(late));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Pulse signs and peak height late in a frame; cleared as each frame starts
	always @(posedge clk) begin
		if (go) begin
			seen <= 2'h0;
			mx <= 6'h0;
		end else if (busy && late && lo[5:0] != 6'h0) begin
			seen <= seen | (lo[6] ? 2'h2 : 2'h1);
			mx <= (lo[5:0] > mx) ? lo[5:0] : mx;
		end
	end
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", name, exp, got);
			fail_count++;
		end
	endtask
	// Response ready stands from the request until the answer is sampled
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge clk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		rs = bresp;
	endtask
	task automatic rd(input logic [9:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		rv = rdata[7:0];
		rs = rresp;
	endtask
	task automatic frame(input logic [7:0] c0, input logic [15:0] p, input logic [15:0] n,
		input logic [1:0] es, input logic [5:0] em);
		wr(10'h008, c0);
		pos <= p;
		neg <= n;
		fall <= c0[3];
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		while (busy) @(posedge clk);
		repeat (4) @(posedge clk);
		chk("pulse signs", {6'h0, es}, {6'h0, seen});
		chk("peak height", {2'h0, em}, {2'h0, mx});
	endtask
	task automatic t_regs();
		rd(10'h010);
		chk("scale reset", 8'h21, rv);
		wr(10'h009, 8'h0f);
		chk("unaligned write", 8'h02, {6'h0, rs});
		rd(10'h3fc);
		chk("unmapped read", 8'h02, {6'h0, rs});
		repeat (100) @(posedge clk);
		wr(10'h05c, 8'hff);
		rd(10'h05c);
		chk("idle clock loss", 8'h01, rv);
		rd(10'h05c);
		chk("status cleared", 8'h00, rv);
	endtask
	task automatic t_ram();
		wr(10'h018, 8'h11);
		wr(10'h014, 8'h80);
		wr(10'h018, 8'h4b);
		wr(10'h014, 8'hbf);
		wr(10'h018, 8'h00);
		wr(10'h014, 8'hff);
		rd(10'h014);
		chk("ram control", 8'h7f, rv);
		rd(10'h018);
		chk("ram sample", 8'h4b, rv);
	endtask
	task automatic t_dual();
		frame(8'h02, 16'haaaa, 16'h5555, 2'h3, 6'h30);
		frame(8'h02, 16'hffff, 16'h0000, 2'h2, 6'h30);
		frame(8'h02, 16'hffff, 16'hffff, 2'h0, 6'h00);
		frame(8'h06, 16'hffff, 16'h0000, 2'h1, 6'h30);
		frame(8'h0a, 16'h0000, 16'hffff, 2'h1, 6'h30);
	endtask
	task automatic t_code();
		frame(8'h00, 16'hffff, 16'hffff, 2'h3, 6'h30);
		frame(8'h00, 16'h0000, 16'h0000, 2'h0, 6'h00);
		frame(8'h01, 16'h0000, 16'h0000, 2'h3, 6'h30);
		wr(10'h100, 8'h01);
		wr(10'h00c, 8'h02);
		frame(8'h00, 16'h0000, 16'h0000, 2'h0, 6'h00);
		frame(8'h01, 16'h0000, 16'h0000, 2'h3, 6'h30);
		wr(10'h00c, 8'h07);
		frame(8'h02, 16'h0000, 16'hffff, 2'h1, 6'h30);
	endtask
	task automatic t_user();
		wr(10'h018, 8'h3f);
		wr(10'h014, 8'h85);
		wr(10'h014, 8'h95);
		wr(10'h048, 8'h02);
		wr(10'h00c, 8'h0c);
		rd(10'h05c);
		frame(8'h02, 16'h0000, 16'hffff, 2'h1, 6'h3f);
		chk("overflow irq", 8'h01, {7'h0, irq});
		rd(10'h05c);
		chk("overflow flag", 8'h02, rv & 8'h02);
		wr(10'h010, 8'h10);
		frame(8'h02, 16'h0000, 16'hffff, 2'h1, 6'h3c);
		wr(10'h00c, 8'h00);
		frame(8'h02, 16'h0000, 16'hffff, 2'h1, 6'h30);
		wr(10'h100, 8'h00);
		wr(10'h00c, 8'h01);
		frame(8'h02, 16'h0000, 16'hffff, 2'h1, 6'h3c);
	endtask
	task automatic t_loss();
		wr(10'h048, 8'h01);
		rd(10'h05c);
		frame(8'h02, 16'haaaa, 16'h5555, 2'h3, 6'h3c);
		// Clock enable low freezes the loss count well past its limit
		ce <= 1'b0;
		repeat (100) @(posedge clk);
		chk("loss frozen", 8'h00, {7'h0, irq});
		ce <= 1'b1;
		repeat (56) @(posedge clk);
		chk("loss early", 8'h00, {7'h0, irq});
		repeat (30) @(posedge clk);
		chk("loss irq", 8'h01, {7'h0, irq});
	endtask
	task automatic stop_test();
		$display("Checks %0d, mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		#500us;
		fail_count++;
		stop_test();
	end
	initial begin
		{rst_n, awvalid, wvalid, bready, arvalid, rready, go, fall} = 8'h0;
		{awaddr, araddr, wdata, pos, neg} = '0;
		ce = 1'b1;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_regs();
		t_ram();
		t_dual();
		t_code();
		t_user();
		t_loss();
		stop_test();
	end
endmodule
